// *** hdl/logic_cell_pkg.sv ***
// Package: register map, field layout and carrier types of the gate select block
package logic_cell_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int GATE_COUNT = 4;
    localparam int DATA_COUNT = 4;
    localparam int CELL_INPUTS = 16;

    typedef logic [3:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
    typedef logic [3:0] data_vec_t;
    typedef logic [2:0] src_sel_t;
    typedef logic [15:0] cell_in_t;

    // ************************************************************
    // Register indices (plain port, one byte per index)
    // ************************************************************
    localparam reg_addr_t GATE1_SEL_IDX = 4'h0;
    localparam reg_addr_t GATE2_SEL_IDX = 4'h1;
    localparam reg_addr_t GATE3_SEL_IDX = 4'h2;
    localparam reg_addr_t GATE4_SEL_IDX = 4'h3;
    localparam reg_addr_t DATA12_SEL_IDX = 4'h4;
    localparam reg_addr_t DATA34_SEL_IDX = 4'h5;
    localparam reg_addr_t MIRROR_IDX = 4'h6;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int TERM_TRUE_OFS = 1;
    localparam int TERM_INV_OFS = 0;
    localparam int TERM_STRIDE = 2;
    localparam int HIGH_SEL_LSB = 4;
    localparam int LOW_SEL_LSB = 0;
    localparam int MIRROR_CELL1_BIT = 0;
    localparam int MIRROR_CELL2_BIT = 1;
    localparam int SEL_RANGE_BIT = 2;
    localparam logic [3:0] D4_LOW_BASE = 4'h0;
    localparam logic [3:0] D4_HIGH_BASE = 4'hc;
    localparam reg_data_t TERM_SEL_RESET = 8'h00;
    localparam reg_data_t SRC_SEL_RESET = 8'h00;
    localparam reg_data_t READ_ZERO = 8'h00;
    localparam logic [1:0] MIRROR_RESET = 2'h0;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic d4_true;
        logic d4_inv;
        logic d3_true;
        logic d3_inv;
        logic d2_true;
        logic d2_inv;
        logic d1_true;
        logic d1_inv;
    } term_sel_t;

    typedef struct packed {
        reg_addr_t addr;
        reg_data_t wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// *** hdl/gate_term_or.sv ***
// One data gate: OR of the enabled true and inverted data terms
`timescale 1ns/100ps
`default_nettype none
module gate_term_or (
    // Term enables for this gate
    input wire logic_cell_pkg::term_sel_t sel,
    // The four selected data signals, true form
    input wire logic_cell_pkg::data_vec_t data,
    // Gate result before any polarity stage
    output logic gate_comb
);
    import logic_cell_pkg::*;

    logic [7:0] sel_bits;
    data_vec_t term_hit;

    assign sel_bits = sel;

    // ************************************************************
    // Per data input: true term and inverted term
    // ************************************************************
    genvar k;
    generate
        for (k = 0; k < DATA_COUNT; k = k + 1) begin : g_term
            // Cleared bit drops that form from the gate [R4]
            assign term_hit[k] = (sel_bits[k*TERM_STRIDE+TERM_TRUE_OFS] & data[k])
                | (sel_bits[k*TERM_STRIDE+TERM_INV_OFS] & ~data[k]);
        end
    endgenerate

    // Empty selection yields zero, since OR of nothing is zero [R10]
    assign gate_comb = |term_hit;

endmodule
`default_nettype wire

// *** hdl/logic_cell_gate_select.sv ***
// Gate select matrix of a logic cell with the shared output mirror register
// Contract
// (R1) Gate two select: d4 true..d1 inverted
// (R2) Gate three select, same bit order
// (R3) Gate four select, same layout
// (R4) Cleared select bit excludes that term
// (R5) Selects read/write; keep value on warm reset
// (R6) Mirror: bit1 cell two, bit0 cell one
// (R7) Mirror upper six bits read zero
// (R8) Gate one select, same layout
// (R9) Data four chosen by three-bit selector
// (R10) Gate ORs enabled terms; none gives zero
`timescale 1ns/100ps
`default_nettype none
module logic_cell_gate_select (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Non power-on reset: clears mirror, keeps selects
    input wire logic warm_rst,
    // Register port
    input wire logic_cell_pkg::reg_req_t reg_req,
    output logic_cell_pkg::reg_data_t rd_data,
    // Cell inputs and the data signals picked elsewhere
    input wire logic_cell_pkg::cell_in_t cell_input_bus,
    input wire logic data1_true,
    input wire logic data2_true,
    input wire logic data3_true,
    // Outputs of the two cells, mirrored for software
    input wire logic cell1_output,
    input wire logic cell2_output,
    // Selector codes for the external data1..3 muxes
    output logic_cell_pkg::src_sel_t data1_source_sel,
    output logic_cell_pkg::src_sel_t data2_source_sel,
    output logic_cell_pkg::src_sel_t data3_source_sel,
    // Data four and the gate results
    output logic data4_sig,
    output logic gate1_out,
    output logic gate2_out,
    output logic gate3_out,
    output logic gate4_out
);
    import logic_cell_pkg::*;

    // ************************************************************
    // Storage
    // ************************************************************
    term_sel_t gate1_term_select_reg;
    term_sel_t gate2_term_select_reg;
    term_sel_t gate3_term_select_reg;
    term_sel_t gate4_term_select_reg;
    src_sel_t data1_sel_reg;
    src_sel_t data2_sel_reg;
    src_sel_t data3_sel_reg;
    src_sel_t data4_source_sel_reg;
    logic [1:0] cell_output_mirror_reg;
    reg_data_t rd_data_reg;
    reg_data_t rd_data_next;
    logic data4_reg;
    logic [3:0] gate_out_reg;

    // ************************************************************
    // Decode
    // ************************************************************
    logic wr_gate1;
    logic wr_gate2;
    logic wr_gate3;
    logic wr_gate4;
    logic wr_data12;
    logic wr_data34;
    logic [3:0] data4_index;
    logic data4_next;
    data_vec_t data_now;
    term_sel_t gate_sel [GATE_COUNT];
    logic [3:0] gate_comb;

    // Write strobes per register; mirror index has none on purpose
    assign wr_gate1 = reg_req.wr && (reg_req.addr == GATE1_SEL_IDX);
    assign wr_gate2 = reg_req.wr && (reg_req.addr == GATE2_SEL_IDX);
    assign wr_gate3 = reg_req.wr && (reg_req.addr == GATE3_SEL_IDX);
    assign wr_gate4 = reg_req.wr && (reg_req.addr == GATE4_SEL_IDX);
    assign wr_data12 = reg_req.wr && (reg_req.addr == DATA12_SEL_IDX);
    assign wr_data34 = reg_req.wr && (reg_req.addr == DATA34_SEL_IDX);

    // ************************************************************
    // Gate select registers
    // ************************************************************
    // Power-on value is unknown in silicon; zero here for a known start.
    // Warm reset does not touch these, so contents survive it.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate1_term_select_reg <= TERM_SEL_RESET;
        end else if (wr_gate1) begin
            gate1_term_select_reg <= reg_req.wdata; // [R8] [R5]
        end
    end

    // Gate two select
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate2_term_select_reg <= TERM_SEL_RESET;
        end else if (wr_gate2) begin
            gate2_term_select_reg <= reg_req.wdata; // [R1] [R5]
        end
    end

    // Gate three select
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate3_term_select_reg <= TERM_SEL_RESET;
        end else if (wr_gate3) begin
            gate3_term_select_reg <= reg_req.wdata; // [R2] [R5]
        end
    end

    // Gate four select
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate4_term_select_reg <= TERM_SEL_RESET;
        end else if (wr_gate4) begin
            gate4_term_select_reg <= reg_req.wdata; // [R3] [R5]
        end
    end

    // ************************************************************
    // Data source selectors
    // ************************************************************
    // Data one and two codes, driven out to the external muxes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data1_sel_reg <= SRC_SEL_RESET[2:0];
            data2_sel_reg <= SRC_SEL_RESET[2:0];
        end else if (wr_data12) begin
            data1_sel_reg <= reg_req.wdata[LOW_SEL_LSB +: 3];
            data2_sel_reg <= reg_req.wdata[HIGH_SEL_LSB +: 3];
        end
    end

    // Data three and four codes; bits 7 and 3 are not stored
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data3_sel_reg <= SRC_SEL_RESET[2:0];
            data4_source_sel_reg <= SRC_SEL_RESET[2:0];
        end else if (wr_data34) begin
            data3_sel_reg <= reg_req.wdata[LOW_SEL_LSB +: 3];
            data4_source_sel_reg <= reg_req.wdata[HIGH_SEL_LSB +: 3];
        end
    end

    assign data1_source_sel = data1_sel_reg;
    assign data2_source_sel = data2_sel_reg;
    assign data3_source_sel = data3_sel_reg;

    // Data four mux: codes 1xx take inputs 0..3, codes 0xx take 12..15
    always_comb begin
        if (data4_source_sel_reg[SEL_RANGE_BIT]) begin
            data4_index = D4_LOW_BASE + {2'h0, data4_source_sel_reg[1:0]}; // [R9]
        end else begin
            data4_index = D4_HIGH_BASE + {2'h0, data4_source_sel_reg[1:0]}; // [R9]
        end
        data4_next = cell_input_bus[data4_index];
    end

    // Registered so data four lines up with the gate outputs
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data4_reg <= 1'b0;
        end else begin
            data4_reg <= data4_next;
        end
    end

    assign data4_sig = data4_reg;

    // ************************************************************
    // Gate matrix
    // ************************************************************
    // Gates see data four straight from the mux, not the delayed copy,
    // so a gate result reflects the inputs of the same cycle.
    assign data_now = {data4_next, data3_true, data2_true, data1_true};

    assign gate_sel[0] = gate1_term_select_reg;
    assign gate_sel[1] = gate2_term_select_reg;
    assign gate_sel[2] = gate3_term_select_reg;
    assign gate_sel[3] = gate4_term_select_reg;

    // One OR stage per gate
    genvar g;
    generate
        for (g = 0; g < GATE_COUNT; g = g + 1) begin : g_gate
            gate_term_or u_gate (
                .sel(gate_sel[g]),
                .data(data_now),
                .gate_comb(gate_comb[g]) // [R10] [R4]
            );
        end
    endgenerate

    // Gate results from flip-flops; polarity is applied downstream
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_out_reg <= 4'h0;
        end else begin
            gate_out_reg <= gate_comb;
        end
    end

    assign gate1_out = gate_out_reg[0];
    assign gate2_out = gate_out_reg[1];
    assign gate3_out = gate_out_reg[2];
    assign gate4_out = gate_out_reg[3];

    // ************************************************************
    // Output mirror
    // ************************************************************
    // Sampled every cycle; any reset clears it. Software writes to the
    // mirror index are dropped: there is no write path at all.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cell_output_mirror_reg <= MIRROR_RESET;
        end else if (warm_rst) begin
            cell_output_mirror_reg <= MIRROR_RESET; // [R6]
        end else begin
            cell_output_mirror_reg[MIRROR_CELL1_BIT] <= cell1_output; // [R6]
            cell_output_mirror_reg[MIRROR_CELL2_BIT] <= cell2_output; // [R6]
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Unmapped indices and unimplemented bits read as zero
    always_comb begin
        rd_data_next = READ_ZERO;
        unique case (reg_req.addr)
            GATE1_SEL_IDX: begin
                rd_data_next = gate1_term_select_reg; // [R5]
            end
            GATE2_SEL_IDX: begin
                rd_data_next = gate2_term_select_reg; // [R5]
            end
            GATE3_SEL_IDX: begin
                rd_data_next = gate3_term_select_reg; // [R5]
            end
            GATE4_SEL_IDX: begin
                rd_data_next = gate4_term_select_reg; // [R5]
            end
            DATA12_SEL_IDX: begin
                rd_data_next[LOW_SEL_LSB +: 3] = data1_sel_reg;
                rd_data_next[HIGH_SEL_LSB +: 3] = data2_sel_reg;
            end
            DATA34_SEL_IDX: begin
                rd_data_next[LOW_SEL_LSB +: 3] = data3_sel_reg;
                rd_data_next[HIGH_SEL_LSB +: 3] = data4_source_sel_reg;
            end
            MIRROR_IDX: begin
                rd_data_next[1:0] = cell_output_mirror_reg; // [R7]
            end
            default: begin
                rd_data_next = READ_ZERO;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_reg <= READ_ZERO;
        end else if (reg_req.rd) begin
            rd_data_reg <= rd_data_next;
        end else begin
            rd_data_reg <= READ_ZERO;
        end
    end

    assign rd_data = rd_data_reg;

endmodule
`default_nettype wire

// *** verif/logic_cell_gate_select_properties.sv ***
// Checker: register port, mirror and gate path relations of the gate select block
`timescale 1ns/100ps
`default_nettype none
module logic_cell_gate_select_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic warm_rst,
    // Register port
    input wire logic_cell_pkg::reg_req_t reg_req,
    input wire logic_cell_pkg::reg_data_t rd_data,
    // Data, cells and results
    input wire logic_cell_pkg::cell_in_t cell_input_bus,
    input wire logic data1_true,
    input wire logic data2_true,
    input wire logic data3_true,
    input wire logic cell1_output,
    input wire logic cell2_output,
    input wire logic data4_sig,
    input wire logic gate1_out,
    input wire logic gate2_out,
    input wire logic gate3_out,
    input wire logic gate4_out
);
    import logic_cell_pkg::*;
    // ********
    // Shadow selects: the checker cannot see inside, so it keeps its own copy
    // ********
    reg_data_t sel_reg [0:5];
    reg_data_t gate_sel_rd;
    src_sel_t c4;
    logic [3:0] d_now;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_reg <= '{default: '0};
        end else if (reg_req.wr && reg_req.addr < 4'h6) begin
            sel_reg[reg_req.addr[2:0]] <= reg_req.wdata;
        end
    end
    // Data four as the mux picks it in the current cycle
    assign c4 = sel_reg[5][6:4];
    assign d_now[3] = cell_input_bus[c4[2] ? {2'b00, c4[1:0]} : {2'b11, c4[1:0]}];
    assign d_now[2:0] = {data3_true, data2_true, data1_true};
    assign gate_sel_rd = sel_reg[{1'b0, reg_req.addr[1:0]}];
    function automatic logic term_or(input reg_data_t s, input logic [3:0] d);
        return |(s & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
    endfunction
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_gate1_terms: assert property (gate1_out == $past(term_or(sel_reg[0], d_now)))
        else $error("gate one differs from its enabled terms");
    a_gate2_terms: assert property (gate2_out == $past(term_or(sel_reg[1], d_now)))
        else $error("gate two differs from its enabled terms");
    a_gate3_terms: assert property (gate3_out == $past(term_or(sel_reg[2], d_now)))
        else $error("gate three differs from its enabled terms");
    a_gate4_terms: assert property (gate4_out == $past(term_or(sel_reg[3], d_now)))
        else $error("gate four differs from its enabled terms");
    a_data4_pick: assert property (data4_sig == $past(d_now[3]))
        else $error("data four took the wrong cell input");
    a_sel_readback: assert property ($past(reg_req.rd) && $past(reg_req.addr) < 4'h4
        |-> rd_data == $past(gate_sel_rd))
        else $error("gate select read back wrong");
    a_mirror_copy: assert property ($past(reg_req.rd) && $past(reg_req.addr) == MIRROR_IDX
        && !$past(warm_rst, 2) |-> rd_data[1:0] == {$past(cell2_output, 2),
        $past(cell1_output, 2)})
        else $error("mirror bits differ from cell outputs");
    // A warm reset one edge before the read must leave the mirror empty
    a_mirror_warm: assert property ($past(reg_req.rd) && $past(reg_req.addr) == MIRROR_IDX
        && $past(warm_rst, 2) |-> rd_data[1:0] == 2'h0)
        else $error("mirror not cleared by warm reset");
    a_mirror_upper: assert property ($past(reg_req.rd) && $past(reg_req.addr) == MIRROR_IDX
        |-> rd_data[7:2] == 6'h00)
        else $error("mirror upper bits not zero");
    a_idle_zero: assert property (!$past(reg_req.rd) |-> rd_data == READ_ZERO)
        else $error("read data not zero outside a read");
endmodule
bind logic_cell_gate_select logic_cell_gate_select_properties u_props (.sys_clk, .arst_n,
    .warm_rst, .reg_req, .rd_data, .cell_input_bus, .data1_true, .data2_true, .data3_true,
    .cell1_output, .cell2_output, .data4_sig, .gate1_out, .gate2_out, .gate3_out, .gate4_out);
`default_nettype wire

// *** verif/logic_cell_gate_select_tb.sv ***
// Testbench: register access, gate routing, data four mux and mirror
`timescale 1ns/100ps
`default_nettype none
module logic_cell_gate_select_tb;
    import logic_cell_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic warm_rst = 1'b0;
    reg_req_t reg_req = '0;
    reg_data_t rd_data;
    cell_in_t cell_input_bus = '0;
    logic data1_true = 1'b0;
    logic data2_true = 1'b0;
    logic data3_true = 1'b0;
    logic cell1_output = 1'b0;
    logic cell2_output = 1'b0;
    src_sel_t data1_source_sel;
    src_sel_t data2_source_sel;
    src_sel_t data3_source_sel;
    logic data4_sig;
    logic gate1_out;
    logic gate2_out;
    logic gate3_out;
    logic gate4_out;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [3:0] d;
    logic [3:0] mask;
    cell_in_t one_hot;
    logic_cell_gate_select dut (.sys_clk, .arst_n, .warm_rst, .reg_req, .rd_data,
        .cell_input_bus, .data1_true, .data2_true, .data3_true, .cell1_output,
        .cell2_output, .data1_source_sel, .data2_source_sel, .data3_source_sel,
        .data4_sig, .gate1_out, .gate2_out, .gate3_out, .gate4_out);
    // ********
    // Clock, hang guard and shared tasks
    // ********
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Whole run is well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input reg_addr_t a, input reg_data_t v);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.wdata <= v;
        reg_req.wr <= 1'b1;
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input reg_addr_t a, input reg_data_t exp);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask
    // Gates and data four settle one edge after the inputs land
    task automatic apply(input logic [2:0] v, input cell_in_t bus);
        @(posedge sys_clk);
        {data3_true, data2_true, data1_true} <= v;
        cell_input_bus <= bus;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            reg_rd(g[3:0], TERM_SEL_RESET);
        end
        reg_rd(MIRROR_IDX, READ_ZERO);
        // One term at a time, other data bits opposite to catch wrong routing
        for (int g = 0; g < 4; g++) begin
            for (int b = 0; b < 8; b++) begin
                reg_wr(g[3:0], 8'h01 << b);
                mask = 4'h1 << (b / 2);
                d = b[0] ? mask : ~mask;
                apply(d[2:0], d[3] ? 16'h1000 : 16'hefff);
                chk({4'h0, gate4_out, gate3_out, gate2_out, gate1_out}, 8'h01 << g);
                d = ~d;
                apply(d[2:0], d[3] ? 16'h1000 : 16'hefff);
                chk({4'h0, gate4_out, gate3_out, gate2_out, gate1_out}, 8'h00);
            end
            reg_wr(g[3:0], 8'h00);
        end
        // Selects survive a warm reset
        reg_wr(GATE1_SEL_IDX, 8'h3c);
        reg_wr(GATE2_SEL_IDX, 8'ha5);
        reg_wr(GATE3_SEL_IDX, 8'h5a);
        reg_wr(GATE4_SEL_IDX, 8'hc3);
        @(posedge sys_clk);
        warm_rst <= 1'b1;
        @(posedge sys_clk);
        warm_rst <= 1'b0;
        reg_rd(GATE2_SEL_IDX, 8'ha5);
        reg_rd(GATE3_SEL_IDX, 8'h5a);
        reg_rd(GATE1_SEL_IDX, 8'h3c);
        reg_rd(GATE4_SEL_IDX, 8'hc3);
        reg_wr(DATA12_SEL_IDX, 8'h53);
        #1;
        chk({2'b00, data2_source_sel, data1_source_sel}, 8'h2b);
        // Every data four code, one-hot and inverted bus
        for (int c = 0; c < 8; c++) begin
            reg_wr(DATA34_SEL_IDX, {1'b0, c[2:0], 4'h0});
            one_hot = 16'h0001 << (c[2] ? c[1:0] : 12 + c[1:0]);
            apply(3'h0, one_hot);
            chk({7'h00, data4_sig}, 8'h01);
            apply(3'h0, ~one_hot);
            chk({7'h00, data4_sig}, 8'h00);
        end
        // Data three code reaches its pin; bit 3 is not stored
        reg_wr(DATA34_SEL_IDX, 8'h5e);
        #1;
        chk({5'h00, data3_source_sel}, 8'h06);
        reg_rd(DATA34_SEL_IDX, 8'h56);
        reg_rd(DATA12_SEL_IDX, 8'h53);
        // Mirror follows the cells; a write there changes nothing
        for (int c = 0; c < 4; c++) begin
            @(posedge sys_clk);
            {cell2_output, cell1_output} <= c[1:0];
            reg_wr(MIRROR_IDX, 8'hff);
            reg_rd(MIRROR_IDX, {6'h00, c[1:0]});
        end
        // Warm reset empties the mirror for one cycle, then it refills
        @(posedge sys_clk);
        warm_rst <= 1'b1;
        reg_req.addr <= MIRROR_IDX;
        @(posedge sys_clk);
        warm_rst <= 1'b0;
        reg_req.rd <= 1'b1;
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1;
        chk(rd_data, READ_ZERO);
        reg_rd(MIRROR_IDX, 8'h03);
        reg_rd(4'h7, READ_ZERO);
        reg_rd(4'hf, READ_ZERO);
        close_out();
    end
endmodule
`default_nettype wire
